// ---- design/srt_timers.sv ----
// Four scheduled run timers gating run permission, reference source and PI control
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module srt_timers #(
  parameter int unsigned NUM_TIMERS = srt_pkg::SRT_TIMERS
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic [srt_pkg::SRT_AW-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [31:0]               reg_rdata,
  input  wire logic [srt_pkg::SRT_TW-1:0] rtc_minute,
  input  wire logic [2:0]                rtc_weekday,
  input  wire logic                      rtc_minute_tick,
  input  wire logic                      run_cmd,
  input  wire logic                      drive_running,
  input  wire logic                      timer_disable_in,
  input  wire logic                      timer_cancel_in,
  output logic      [NUM_TIMERS-1:0]     timer_active_out,
  output srt_pkg::srt_ctl_s              drive_ctl
);

  // Index width of the governing-timer number
  localparam int unsigned IW = (NUM_TIMERS > 1) ? $clog2(NUM_TIMERS) : 1;

  // The status word and the config stride leave room for four timers only
  if ((NUM_TIMERS < 1) || (NUM_TIMERS > srt_pkg::SRT_TIMERS))
  begin : g_bad_count
    $error("NUM_TIMERS must be 1 to 4");
  end

  // Reset release synchroniser; the first stage feeds only the second
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // Register decode
  logic                 cfg_hit;      // Address falls in the config block
  logic [IW-1:0]        cfg_idx;      // Timer addressed by a config access
  logic                 stat_hit;     // Status word addressed
  logic                 clk_hit;      // Clock readback addressed
  assign cfg_hit  = (reg_addr[srt_pkg::SRT_AW-1:2] < NUM_TIMERS[srt_pkg::SRT_AW-3:0])
                    && (reg_addr[1:0] == 2'h0);
  assign cfg_idx  = reg_addr[IW+1:2];
  assign stat_hit = (reg_addr == srt_pkg::SRT_REG_STATUS);
  assign clk_hit  = (reg_addr == srt_pkg::SRT_REG_CLOCK);

  // Neighbouring weekdays, needed to find the first and last selected day
  logic [2:0] wd_prev;
  logic [2:0] wd_next;
  assign wd_prev = (rtc_weekday == srt_pkg::SRT_WD_MON) ? srt_pkg::SRT_WD_SUN
                                                        : rtc_weekday - 3'h1;
  assign wd_next = (rtc_weekday == srt_pkg::SRT_WD_SUN) ? srt_pkg::SRT_WD_MON
                                                        : rtc_weekday + 3'h1;

  // Edge detectors on the run command and the cancel input
  logic run_q_r;
  logic cancel_q_r;
  logic run_rise;
  logic cancel_rise;
  assign run_rise    = run_cmd & ~run_q_r;
  assign cancel_rise = timer_cancel_in & ~cancel_q_r;

  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      run_q_r    <= 1'b0;
      cancel_q_r <= 1'b0;
    end
    else
    begin
      run_q_r    <= run_cmd;
      cancel_q_r <= timer_cancel_in;
    end
  end

  // Per-timer state and settings
  srt_pkg::srt_cfg_s    cfg_r      [NUM_TIMERS];   // Settings, one word per timer
  logic [NUM_TIMERS-1:0] sched_r;                  // Inside its scheduled window
  logic [NUM_TIMERS-1:0] cancel_r;                 // Suspended by the cancel input
  logic [NUM_TIMERS-1:0] live;                     // Scheduled and not cancelled
  logic [NUM_TIMERS-1:0] run_cand;                 // Live with a run action
  logic [NUM_TIMERS-1:0] run_cfg;                  // Configured to govern the run command
  logic [NUM_TIMERS-1:0] alt_live;                 // Live with the alternation action

  // One identical slice per timer, each with its own settings
  for (genvar i = 0; i < NUM_TIMERS; i++)
  begin : g_timer
    logic        hit_today;   // Today selected
    logic        hit_prev;    // Yesterday selected
    logic        hit_next;    // Tomorrow selected
    logic        equal_mode;  // Start equals stop
    logic [10:0] stop_at;     // Stop time with 24:00 folded to midnight
    logic        at_start;    // Minute boundary at the start time
    logic        at_stop;     // Minute boundary at the stop time
    logic        at_midnight; // Minute boundary at midnight
    logic        start_ev;    // Scheduled occurrence begins
    logic        stop_ev;     // Scheduled occurrence ends
    logic        sched_nxt;
    logic        cancel_nxt;
    logic        wr_me;

    // Day codes 0..10 decoded against the clock weekday
    assign hit_today   = srt_pkg::srt_day_hit(cfg_r[i].day, rtc_weekday);
    assign hit_prev    = srt_pkg::srt_day_hit(cfg_r[i].day, wd_prev);
    assign hit_next    = srt_pkg::srt_day_hit(cfg_r[i].day, wd_next);
    assign equal_mode  = (cfg_r[i].start == cfg_r[i].stop);
    assign stop_at     = (cfg_r[i].stop == srt_pkg::SRT_DAY_END) ? srt_pkg::SRT_MIDNIGHT
                                                                 : cfg_r[i].stop;
    // Times are matched only on the minute boundary pulse
    assign at_start    = rtc_minute_tick && (rtc_minute == cfg_r[i].start);
    assign at_stop     = rtc_minute_tick && (rtc_minute == stop_at);
    assign at_midnight = rtc_minute_tick && (rtc_minute == srt_pkg::SRT_MIDNIGHT);

    // Window mode: begin on a selected day, end at the stop time even on the
    // next day, so a start later than the stop wraps past midnight
    // Equal mode: begin on the first selected day, stop at that time on the
    // last one, and a lone selected day ends at midnight
    assign start_ev = equal_mode ? (at_start && hit_today && !(hit_prev && !hit_next))
                                 : (at_start && hit_today);
    assign stop_ev  = equal_mode ? ((at_start && hit_today && hit_prev && !hit_next)
                                    || (at_midnight && !hit_today)
                                    || (at_start && !hit_today))
                                 : at_stop;

    // A begin in the same minute as an end wins, so back-to-back days join
    assign sched_nxt = (cfg_r[i].day == srt_pkg::SRT_DAY_OFF) ? 1'b0 :
                       start_ev ? 1'b1 :
                       stop_ev  ? 1'b0 : sched_r[i];

    // Cancel edge suspends a running timer; it clears on the next scheduled
    // begin or a fresh run command
    assign cancel_nxt = (cancel_rise && sched_r[i]) ? 1'b1 :
                        (start_ev || run_rise)      ? 1'b0 : cancel_r[i];

    assign live[i]     = sched_r[i] & ~cancel_r[i];
    assign run_cfg[i]  = (cfg_r[i].day != srt_pkg::SRT_DAY_OFF)
                         && ((cfg_r[i].action == srt_pkg::SRT_ACT_RUN)
                             || (cfg_r[i].action == srt_pkg::SRT_ACT_NOPI));
    assign run_cand[i] = live[i] & run_cfg[i];
    assign alt_live[i] = live[i] && (cfg_r[i].action == srt_pkg::SRT_ACT_ALTER);
    assign wr_me       = reg_wr && cfg_hit && (cfg_idx == IW'(i));

    // Timer state and settings
    always_ff @(posedge clk_sys or negedge rst_sync_n)
    begin
      if (!rst_sync_n)
      begin
        cfg_r[i]    <= srt_pkg::SRT_CFG_RESET;
        sched_r[i]  <= 1'b0;
        cancel_r[i] <= 1'b0;
      end
      else
      begin
        if (wr_me)
          cfg_r[i]  <= srt_pkg::srt_cfg_s'(reg_wdata[srt_pkg::SRT_CFG_W-1:0]);
        sched_r[i]  <= sched_nxt;
        cancel_r[i] <= cancel_nxt;
      end
    end
  end

  // Lowest numbered live run timer governs
  logic [IW-1:0] win_idx;
  logic          win_valid;
  always_comb
  begin
    win_idx   = '0;
    win_valid = 1'b0;
    for (int k = NUM_TIMERS - 1; k >= 0; k--)
    begin
      if (run_cand[k])
      begin
        win_idx   = k[IW-1:0];
        win_valid = 1'b1;
      end
    end
  end

  // Timers steer run, reference and PI only when one is set to run and not disabled; alternation follows action-3 timers regardless
  logic              sched_ctl;
  srt_pkg::srt_cfg_s win_cfg;
  srt_pkg::srt_ctl_s ctl_nxt;
  assign sched_ctl = (|run_cfg) && !timer_disable_in;
  assign win_cfg   = cfg_r[win_idx];

  // Without timer control the normal run source passes straight through
  assign ctl_nxt.run_permit      = run_cmd && (!sched_ctl || win_valid);
  // Governing timer supplies the reference source
  assign ctl_nxt.ref_override    = sched_ctl && win_valid;
  assign ctl_nxt.ref_src         = win_cfg.ref_src;
  // PI loop off while an action-2 timer governs
  assign ctl_nxt.pi_off          = sched_ctl && win_valid
                                   && (win_cfg.action == srt_pkg::SRT_ACT_NOPI);
  // Operator panel status
  assign ctl_nxt.show_timer_run  = sched_ctl && win_valid && drive_running;
  assign ctl_nxt.show_timer_off  = sched_ctl && run_cmd && !win_valid;
  // Bus voltage excursions become alarms while parked by the schedule
  assign ctl_nxt.volt_alarm_only = sched_ctl && run_cmd && !win_valid;
  assign ctl_nxt.alternate_ok    = |alt_live;

  // Read data multiplexer; unmapped addresses read as zero
  logic [31:0] rd_mux;
  assign rd_mux = cfg_hit  ? {1'b0, cfg_r[cfg_idx]} :
                  stat_hit ? {{(32-2*NUM_TIMERS-IW-1){1'b0}}, win_idx, win_valid,
                              cancel_r, sched_r} :
                  clk_hit  ? {18'h00000, rtc_weekday, rtc_minute} : 32'h0000_0000;

  // Registered outputs: activity pins ignore the action code
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      timer_active_out <= '0;
      drive_ctl        <= srt_pkg::SRT_CTL_RESET;
      reg_rdata        <= 32'h0000_0000;
    end
    else
    begin
      timer_active_out <= live;
      drive_ctl        <= ctl_nxt;
      // Read data stand only in the cycle after the strobe
      reg_rdata        <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// ---- inc/srt_pkg.sv ----
// Shared constants, field layouts and carrier types for the scheduled run timers
package srt_pkg;

  // Time of day is carried as minutes since midnight
  localparam int unsigned SRT_TIMERS     = 4;
  localparam int unsigned SRT_TW         = 11;
  localparam logic [10:0] SRT_MIDNIGHT   = 11'h000;
  localparam logic [10:0] SRT_DAY_END    = 11'h5A0;   // 24:00 as a stop time

  // Weekday numbering of the clock input
  localparam logic [2:0]  SRT_WD_MON     = 3'h0;
  localparam logic [2:0]  SRT_WD_FRI     = 3'h4;
  localparam logic [2:0]  SRT_WD_SAT     = 3'h5;
  localparam logic [2:0]  SRT_WD_SUN     = 3'h6;

  // Day selection codes
  localparam logic [3:0]  SRT_DAY_OFF    = 4'h0;
  localparam logic [3:0]  SRT_DAY_DAILY  = 4'h1;
  localparam logic [3:0]  SRT_DAY_WORK   = 4'h2;
  localparam logic [3:0]  SRT_DAY_WEEKND = 4'h3;
  localparam logic [3:0]  SRT_DAY_SINGLE = 4'h4;      // 4 is Monday .. 10 is Sunday
  localparam logic [3:0]  SRT_DAY_LAST   = 4'hA;

  // Action selection codes
  localparam logic [1:0]  SRT_ACT_OUTPUT = 2'h0;
  localparam logic [1:0]  SRT_ACT_RUN    = 2'h1;
  localparam logic [1:0]  SRT_ACT_NOPI   = 2'h2;
  localparam logic [1:0]  SRT_ACT_ALTER  = 2'h3;

  // Register map, byte addresses on the plain register port
  localparam int unsigned SRT_AW         = 8;
  localparam logic [7:0]  SRT_REG_CFG0   = 8'h00;     // One config word per timer, stride 4
  localparam logic [7:0]  SRT_REG_STATUS = 8'h10;
  localparam logic [7:0]  SRT_REG_CLOCK  = 8'h14;

  // Per-timer configuration word, low bits first: start, stop, day, action, reference
  typedef struct packed {
    logic [2:0]  ref_src;
    logic [1:0]  action;
    logic [3:0]  day;
    logic [10:0] stop;
    logic [10:0] start;
  } srt_cfg_s;
  localparam int unsigned SRT_CFG_W      = 31;
  localparam srt_cfg_s    SRT_CFG_RESET  = '{ref_src: 3'h0, action: 2'h0, day: 4'h0,
                                              stop: 11'h000, start: 11'h000};

  // Control bundle handed to the run-command and reference logic
  typedef struct packed {
    logic        run_permit;
    logic        ref_override;
    logic [2:0]  ref_src;
    logic        pi_off;
    logic        show_timer_run;
    logic        show_timer_off;
    logic        volt_alarm_only;
    logic        alternate_ok;
  } srt_ctl_s;
  localparam srt_ctl_s    SRT_CTL_RESET  = '0;

  // True when the day code selects the given weekday
  function automatic logic srt_day_hit(input logic [3:0] code, input logic [2:0] wd);
    logic hit;
    hit = 1'b0;
    if (code == SRT_DAY_DAILY)
      hit = 1'b1;
    else if (code == SRT_DAY_WORK)
      hit = (wd <= SRT_WD_FRI);
    else if (code == SRT_DAY_WEEKND)
      hit = (wd == SRT_WD_SAT) || (wd == SRT_WD_SUN);
    else if ((code >= SRT_DAY_SINGLE) && (code <= SRT_DAY_LAST))
      hit = ({1'b0, wd} == (code - SRT_DAY_SINGLE));
    return hit;
  endfunction

endpackage

// ---- sim/srt_drive_model.sv ----
// Behavioural run-command logic of the drive that consumes the timer controls
`timescale 1ns/1ps
`default_nettype none
module srt_drive_model (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              slow,           // Adds one cycle of start and stop lag
  input wire srt_pkg::srt_ctl_s drive_ctl,
  output logic                  drive_running
);
  logic lag_r;   // Permission seen one cycle back

  // Drive runs only while permitted; a slow drive reacts a cycle late
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lag_r         <= 1'b0;
      drive_running <= 1'b0;
    end
    else
    begin
      lag_r         <= drive_ctl.run_permit;
      drive_running <= slow ? lag_r : drive_ctl.run_permit;
    end
  end
endmodule
`default_nettype wire

// ---- sim/srt_timers_bench.sv ----
// Self-checking bench for the scheduled run timers with its own reference model
`timescale 1ns/1ps
`default_nettype none
module srt_timers_bench;
  logic              clk_sys, rst_n, reg_wr, reg_rd, rtc_minute_tick, slow;
  logic              run_cmd, timer_disable_in, timer_cancel_in, drive_running;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [10:0]       rtc_minute;
  logic [2:0]        rtc_weekday;
  logic [3:0]        timer_active_out;
  srt_pkg::srt_ctl_s drive_ctl;
  int                n_errors, check_count, seed;
  int                c_s[4], c_e[4], c_d[4], c_a[4], c_r[4];  // Model copy of settings
  bit                m_act[4], m_can[4];                      // Model schedule and cancels
  logic [31:0]       exp_q[$];                                // Words awaiting readback

  srt_timers #(.NUM_TIMERS(4)) u_srt_timers (.clk_sys, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .rtc_minute, .rtc_weekday, .rtc_minute_tick, .run_cmd,
    .drive_running, .timer_disable_in, .timer_cancel_in, .timer_active_out, .drive_ctl);
  srt_drive_model u_srt_drive_model (.clk_sys, .rst_n, .slow, .drive_ctl, .drive_running);

  // Free-running 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Model's own reading of the day codes, weekday 0 is Monday
  function automatic bit day_ok(int d, int w);
    return d == 1 || (d == 2 && w < 5) || (d == 3 && w >= 5) || (d >= 4 && d <= 10 && d - 4 == w);
  endfunction

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Register write and read, one strobe cycle each
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk("read data", e, reg_rdata);
  endtask

  task automatic cfg(int i, int s, int e, int d, int a, int r);
    c_s[i] = s;
    c_e[i] = e;
    c_d[i] = d;
    c_a[i] = a;
    c_r[i] = r;
    wr(8'(4 * i), 32'(s) | (32'(e) << 11) | (32'(d) << 22) | (32'(a) << 26) | (32'(r) << 28));
  endtask

  // Model outputs against the design; only timers with action 1 or 2 steer run, reference and PI
  task automatic settle(int n);
    int g;
    bit live, apply, alt, gov;
    repeat (n) @(posedge clk_sys);
    #1;
    g = -1;
    apply = 0;
    alt = 0;
    for (int i = 3; i >= 0; i--)
    begin
      live = m_act[i] && !m_can[i];
      if (live && (c_a[i] == 1 || c_a[i] == 2))
        g = i;                                                    // Lowest live index wins
      apply = apply || ((c_a[i] == 1 || c_a[i] == 2) && c_d[i] != 0);
      alt = alt || (live && c_a[i] == 3);
      chk("activity", 32'(live), 32'(timer_active_out[i]));
    end
    apply = apply && !timer_disable_in;
    gov = apply && g >= 0;                                        // A run timer governs
    chk("permit", 32'(apply ? run_cmd && g >= 0 : run_cmd), 32'(drive_ctl.run_permit));
    chk("override", 32'(apply && g >= 0), 32'(drive_ctl.ref_override));
    chk("pi off", 32'(apply && g >= 0 && c_a[g] == 2), 32'(drive_ctl.pi_off));
    chk("timer off", 32'(apply && run_cmd && g < 0), 32'(drive_ctl.show_timer_off));
    chk("alternate", 32'(alt), 32'(drive_ctl.alternate_ok));
    chk("volt", 32'(apply && run_cmd && g < 0), 32'(drive_ctl.volt_alarm_only));
    chk("timer run", 32'(gov && drive_running), 32'(drive_ctl.show_timer_run));
    if (apply && g >= 0)
      chk("ref source", 32'(c_r[g]), 32'(drive_ctl.ref_src));
  endtask

  // Minute tick; equal times run from the first selected day to the last one,
  // and end at midnight of an unselected day
  task automatic tick(int mi, int wd);
    bit today, last;
    @(posedge clk_sys);
    rtc_minute      <= 11'(mi);
    rtc_weekday     <= 3'(wd);
    rtc_minute_tick <= 1'b1;
    @(posedge clk_sys);
    rtc_minute_tick <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      today = day_ok(c_d[i], wd);
      last  = day_ok(c_d[i], (wd + 6) % 7) && !day_ok(c_d[i], (wd + 1) % 7);
      if (mi == c_s[i] && today && !(c_s[i] == c_e[i] && last))
      begin
        m_act[i] = 1;
        m_can[i] = 0;
      end
      else if (c_s[i] != c_e[i] ? mi == c_e[i] % 1440
                                : (mi == 0 && !today) || (mi == c_s[i] && today))
        m_act[i] = 0;
    end
    // Long enough for a slow drive to start and the run status to follow
    settle(5);
  endtask

  // Level inputs; a run restart clears cancels, a cancel edge suspends active timers
  task automatic drv(bit r, bit d, bit c);
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      if (r && !run_cmd)
        m_can[i] = 0;
      if (c && !timer_cancel_in)
        m_can[i] = m_can[i] || m_act[i];
    end
    run_cmd          <= r;
    timer_disable_in <= d;
    timer_cancel_in  <= c;
    settle(5);
  endtask

  // Main sequence
  initial
  begin
    seed = 37;
    {rst_n, reg_wr, reg_rd, rtc_minute_tick, run_cmd, timer_disable_in, timer_cancel_in} = '0;
    {reg_addr, reg_wdata, slow} = '0;
    rtc_minute  = 11'd1234;
    rtc_weekday = 3'h3;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0000_1CD2);
    rd(8'h18, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      exp_q.push_back({1'b0, 31'($random(seed))});
      wr(8'(4 * i), exp_q[i]);
    end
    for (int i = 0; i < 4; i++)
      rd(8'(4 * i), exp_q.pop_front());
    slow <= 1'b1;
    cfg(0, 300, 900, 2, 1, 3);
    cfg(1, 600, 1000, 1, 2, 5);
    cfg(2, 600, 600, 4, 0, 0);
    cfg(3, 1380, 60, 3, 3, 7);
    drv(1, 0, 0);
    tick(300, 5);
    tick(300, 0);
    drv(1, 0, 1);
    drv(0, 0, 0);
    drv(1, 0, 0);
    slow <= 1'b0;
    tick(600, 0);
    drv(1, 1, 0);
    drv(1, 0, 0);
    tick(900, 0);
    tick(1000, 0);
    tick(0, 1);
    tick(1380, 1);
    tick(1380, 5);
    tick(60, 6);
    cfg(2, 600, 600, 2, 0, 0);
    tick(600, 0);
    tick(0, 1);
    tick(600, 4);
    drv(0, 0, 0);
    stop_test();
  end

  // Watchdog: the whole run needs about 0.8 us
  initial
  begin
    #50us;
    n_errors++;
    stop_test();
  end
endmodule

bind srt_timers srt_timers_properties #(.NUM_TIMERS(NUM_TIMERS)) u_srt_timers_properties (
  .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rtc_minute,
  .rtc_weekday, .rtc_minute_tick, .run_cmd, .drive_running, .timer_disable_in,
  .timer_cancel_in, .timer_active_out, .drive_ctl);
`default_nettype wire

// ---- sim/srt_timers_properties.sv ----
// Port-level assertions for the scheduled run timers
`timescale 1ns/1ps
`default_nettype none
module srt_timers_properties #(
  parameter int unsigned NUM_TIMERS = srt_pkg::SRT_TIMERS
) (
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic [srt_pkg::SRT_AW-1:0] reg_addr,
  input wire logic [31:0]                reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [31:0]                reg_rdata,
  input wire logic [srt_pkg::SRT_TW-1:0] rtc_minute,
  input wire logic [2:0]                 rtc_weekday,
  input wire logic                       rtc_minute_tick,
  input wire logic                       run_cmd,
  input wire logic                       drive_running,
  input wire logic                       timer_disable_in,
  input wire logic                       timer_cancel_in,
  input wire logic [NUM_TIMERS-1:0]      timer_active_out,
  input wire srt_pkg::srt_ctl_s          drive_ctl
);
  logic [1:0] up_q;   // Edges since release, saturating
  logic       up;     // High once the reset synchroniser has let go
  assign up = (up_q == 2'h3);

  // Count edges after release so history from inside reset is never judged
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      up_q <= 2'h0;
    else if (!up)
      up_q <= up_q + 2'h1;
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // A read of the clock word, one strobe cycle
  sequence clock_rd_s;
    up && reg_rd && reg_addr == srt_pkg::SRT_REG_CLOCK;
  endsequence

  act_rise_cause_a: assert property (up && |(timer_active_out & ~$past(timer_active_out))
    |-> $past(rtc_minute_tick, 2) || ($past(run_cmd) && !$past(run_cmd, 4)))
    else $error("activity began without a tick or a run restart");
  disable_gate_a: assert property (up && $past(timer_disable_in) |->
    !drive_ctl.ref_override && !drive_ctl.pi_off && drive_ctl.run_permit == $past(run_cmd))
    else $error("timers still steer the drive while disabled");
  permit_cmd_a: assert property (up && drive_ctl.run_permit |-> $past(run_cmd))
    else $error("run permitted without a run command");
  pi_governs_a: assert property (drive_ctl.pi_off |-> drive_ctl.ref_override)
    else $error("loop forced off with no governing timer");
  off_blocks_a: assert property (up && drive_ctl.show_timer_off |->
    !drive_ctl.run_permit && $past(run_cmd))
    else $error("timer-off status inconsistent with run permission");
  run_status_a: assert property (up && drive_ctl.show_timer_run |->
    $past(drive_running) && !drive_ctl.show_timer_off)
    else $error("timer-run status without a running drive");
  volt_alarm_a: assert property (drive_ctl.volt_alarm_only == drive_ctl.show_timer_off)
    else $error("voltage alarm mode differs from timer-off status");
  rdata_idle_a: assert property (up && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data present without a read");
  clock_read_a: assert property (clock_rd_s ##1 1'b1 |->
    reg_rdata == {18'h0, $past(rtc_weekday), $past(rtc_minute)})
    else $error("clock word does not show weekday and minute");
endmodule
`default_nettype wire
